// ===== include/timer8_link_if.sv
// Purpose: Carries clock ticks and waveform events between timer parts.
// Assumes: All signals are on the one block clock.
// Notes: Event signals are one-cycle pulses, except ev_up, which is a level held while counting up.
`timescale 1ns/1ps
interface timer8_link_if;
  logic src_tick;
  logic [2:0] clock_select;
  logic count_tick;
  timer8_pkg::wave_mode_e mode;
  timer8_pkg::com_mode_e com;
  logic ev_match;
  logic ev_up;
  logic ev_bottom;
  logic ev_top;
  logic ev_force;
  logic wave_out;

  modport main (output src_tick, clock_select, mode, com, ev_match,
    ev_up, ev_bottom, ev_top, ev_force, input count_tick, wave_out);
  modport pre (input src_tick, clock_select, output count_tick);
  modport wave (input mode, com, ev_match, ev_up, ev_bottom, ev_top,
    ev_force, output wave_out);
endinterface : timer8_link_if

// ===== include/timer8_pkg.sv
// Purpose: Shared constants and types of the 8-bit timer/counter block.
// Assumes: One 100 MHz clock; registers reached by I/O offset.
// Notes: Every offset, bit position and reset value lives here.
package timer8_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_COUNT = 8'h32;
  localparam logic [7:0] OFF_CTRL = 8'h33;
  localparam logic [7:0] OFF_DATA_SPACE = 8'h20;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int BIT_FORCE = 7;
  localparam int BIT_WAVE_HI = 6;
  localparam int BIT_COM_HI = 5;
  localparam int BIT_COM_LO = 4;
  localparam int BIT_WAVE_LO = 3;
  localparam int BIT_CS_HI = 2;
  localparam int BIT_CS_LO = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;

  // ****************************************************************
  // Counter values and prescaler
  // ****************************************************************
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam int PRESCALE_BITS = 10;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE_PWM = 2'h1,
    MODE_CLEAR_ON_MATCH = 2'h2,
    MODE_FAST_PWM = 2'h3
  } wave_mode_e;

  typedef enum logic [1:0] {
    COM_OFF = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_CLEAR = 2'h2,
    COM_SET = 2'h3
  } com_mode_e;

endpackage : timer8_pkg

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the 8-bit timer control block.
// Assumes: Inputs change on the falling edge of a 100 MHz clock.
// Notes: Register rows first, then reset, force and timing cases.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic ds;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;
  row_s rows[7] = '{'{1'h0, 8'h33, 8'hF8, 8'h78},
    '{1'h1, 8'h53, 8'h20, 8'h20}, '{1'h1, 8'h33, 8'h07, 8'h00},
    '{1'h0, 8'h53, 8'h07, 8'h00}, '{1'h0, 8'h34, 8'hFF, 8'h00},
    '{1'h0, 8'h32, 8'hA5, 8'hA5}, '{1'h1, 8'h52, 8'h5A, 8'h5A}};
  logic [7:0] fv[8] = '{8'hB0, 8'hA0, 8'h90, 8'h90, 8'hF0, 8'hE8,
    8'hA8, 8'hE0};
  logic fp[8] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0};
  int dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] v;
  logic p0;
  logic clk, rst, io_data_space, io_write, io_read, compare_value_write;
  logic [7:0] io_addr, io_wdata, io_rdata, compare_value_wdata;
  logic compare_flag_clear, overflow_flag_clear, compare_match_flag;
  logic overflow_flag, async_clock_select, osc_pin;
  logic waveform_output_pin, waveform_output_override;

  timer8_control_and_counter i_timer8_control_and_counter (
    .clk(clk), .rst(rst), .io_addr(io_addr),
    .io_data_space(io_data_space), .io_write(io_write),
    .io_read(io_read), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .compare_value_write(compare_value_write),
    .compare_value_wdata(compare_value_wdata),
    .compare_flag_clear(compare_flag_clear),
    .overflow_flag_clear(overflow_flag_clear),
    .compare_match_flag(compare_match_flag),
    .overflow_flag(overflow_flag),
    .async_clock_select(async_clock_select), .osc_pin(osc_pin),
    .waveform_output_pin(waveform_output_pin),
    .waveform_output_override(waveform_output_override)
  );

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic io_wr(input logic ds, input logic [7:0] a, d);
    @(negedge clk);
    io_data_space = ds;
    io_addr = a;
    io_wdata = d;
    io_write = 1'h1;
    @(negedge clk);
    io_write = 1'h0;
  endtask : io_wr

  task automatic io_rd(input logic ds, input logic [7:0] a,
    output logic [7:0] d);
    @(negedge clk);
    io_data_space = ds;
    io_addr = a;
    io_read = 1'h1;
    @(negedge clk);
    io_read = 1'h0;
    @(negedge clk);
    d = io_rdata;
  endtask : io_rd

  task automatic cmp_wr(input logic [7:0] d);
    @(negedge clk);
    compare_value_wdata = d;
    compare_value_write = 1'h1;
    @(negedge clk);
    compare_value_write = 1'h0;
  endtask : cmp_wr

  task automatic clr();
    @(negedge clk);
    compare_flag_clear = 1'h1;
    overflow_flag_clear = 1'h1;
    @(negedge clk);
    compare_flag_clear = 1'h0;
    overflow_flag_clear = 1'h0;
  endtask : clr

  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask : run

  // Bounded wait; the caller checks the flag afterwards.
  task automatic wait_flag(input logic ovf, input int n);
    for (int i = 0; i < n; i++) begin
      if ((ovf ? overflow_flag : compare_match_flag) === 1'h1) break;
      @(negedge clk);
    end
  endtask : wait_flag

  task automatic pulse_reset();
    rst = 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
  endtask : pulse_reset

  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Longest case is the divide-by-1024 run, about 4100 cycles.
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    {io_data_space, io_write, io_read, io_addr, io_wdata} = '0;
    {compare_value_write, compare_value_wdata, compare_flag_clear} = '0;
    {overflow_flag_clear, async_clock_select, osc_pin} = '0;
    pulse_reset();
    foreach (rows[i]) begin
      io_wr(rows[i].ds, rows[i].addr, rows[i].wdata);
      io_rd(rows[i].ds, rows[i].addr, v);
      chk("register row", v, rows[i].exp);
    end
    pulse_reset();
    io_rd(1'h0, timer8_pkg::OFF_CTRL, v);
    chk("control after reset", v, timer8_pkg::RST_CTRL);
    io_rd(1'h1, 8'h52, v);
    chk("count after reset", v, timer8_pkg::RST_COUNT);
    v = {6'h0, waveform_output_override, waveform_output_pin};
    chk("pin after reset", v, 8'h00);
    io_wr(1'h0, timer8_pkg::OFF_COUNT, 8'h40);
    foreach (fv[i]) begin
      io_wr(1'h0, timer8_pkg::OFF_CTRL, fv[i]);
      run(2);
      v = {7'h0, waveform_output_pin};
      chk("forced pin", v, {7'h0, fp[i]});
      v = {6'h0, compare_match_flag, overflow_flag};
      chk("force flags", v, 8'h00);
    end
    io_rd(1'h0, timer8_pkg::OFF_COUNT, v);
    chk("count after force", v, 8'h40);
    v = {7'h0, waveform_output_override};
    chk("override", v, 8'h01);
    foreach (dv[i]) begin
      io_wr(1'h0, timer8_pkg::OFF_CTRL, 8'(i + 1));
      io_wr(1'h0, timer8_pkg::OFF_COUNT, 8'hFC);
      clr();
      run(3 * dv[i] - 3);
      v = {7'h0, overflow_flag};
      chk("early overflow", v, 8'h00);
      wait_flag(1'h1, dv[i] + 12);
      v = {7'h0, overflow_flag};
      chk("overflow", v, 8'h01);
    end
    io_wr(1'h0, timer8_pkg::OFF_CTRL, 8'h00);
    io_wr(1'h0, timer8_pkg::OFF_COUNT, 8'hFF);
    clr();
    run(50);
    io_rd(1'h0, timer8_pkg::OFF_COUNT, v);
    chk("stopped count", v, 8'hFF);
    cmp_wr(8'h10);
    io_wr(1'h0, timer8_pkg::OFF_CTRL, 8'h11);
    io_wr(1'h0, timer8_pkg::OFF_COUNT, 8'h10);
    clr();
    p0 = waveform_output_pin;
    run(200);
    v = {7'h0, compare_match_flag};
    chk("blocked match", v, 8'h00);
    wait_flag(1'h0, 80);
    run(2);
    v = {6'h0, compare_match_flag, waveform_output_pin};
    chk("match and toggle", v, {6'h0, 1'h1, ~p0});
    io_wr(1'h0, timer8_pkg::OFF_CTRL, 8'h09);
    io_wr(1'h0, timer8_pkg::OFF_COUNT, 8'h02);
    clr();
    run(300);
    v = {7'h0, overflow_flag};
    chk("overflow at max", v, 8'h00);
    wait_flag(1'h1, 260);
    v = {7'h0, overflow_flag};
    chk("overflow at bottom", v, 8'h01);
    for (int k = 0; k < 2; k++) begin
      cmp_wr(k == 0 ? 8'h80 : 8'hFF);
      io_wr(1'h0, timer8_pkg::OFF_CTRL, 8'h69);
      clr();
      wait_flag(1'h1, 300);
      clr();
      wait_flag(1'h1, 300);
      run(10);
      v = {7'h0, waveform_output_pin};
      chk("pin after bottom", v, 8'h01);
      run(180);
      v = {7'h0, waveform_output_pin};
      chk("pin after match", v, {7'h0, k[0]});
    end
    report_and_stop();
  end
endmodule : testbench

// ===== testbench/timer8_assertions.sv
// Purpose: Concurrent checks on the timer control block ports.
// Assumes: One clock; asynchronous active-high reset.
// Notes: A count of stopped cycles tells when no tick may arrive.
`timescale 1ns/1ps
module timer8_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] io_addr,
  input wire logic io_data_space,
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Flags and pin
  input wire logic compare_flag_clear,
  input wire logic compare_match_flag,
  input wire logic overflow_flag,
  input wire logic waveform_output_pin,
  input wire logic waveform_output_override
);
  localparam logic [7:0] DS = timer8_pkg::OFF_DATA_SPACE;
  logic ctrl_hit;
  logic count_hit;
  logic ctrl_wr;
  logic [3:0] stop_cnt;
  assign ctrl_hit = io_addr ==
    8'(timer8_pkg::OFF_CTRL + (io_data_space ? DS : 8'h00));
  assign count_hit = io_addr ==
    8'(timer8_pkg::OFF_COUNT + (io_data_space ? DS : 8'h00));
  assign ctrl_wr = io_write && ctrl_hit;
  // Six idle cycles cover the tick pipeline after a stop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_cnt <= 4'h0;
    end else if (ctrl_wr) begin
      stop_cnt <= (io_wdata[2:0] == 3'h0) ? 4'h1 : 4'h0;
    end else if (stop_cnt != 4'h0 && stop_cnt != 4'hF) begin
      stop_cnt <= stop_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_FORCE_READS_ZERO: assert property (
    io_read && ctrl_hit |=> !io_rdata[7])
    else $error("control read shows the force bit");
  AST_UNMAPPED_READ: assert property (
    io_read && !ctrl_hit && !count_hit |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLDS: assert property (
    !io_read |=> $stable(io_rdata))
    else $error("read data moved without a read");
  AST_OVERRIDE: assert property (
    ctrl_wr ##1 !ctrl_wr |=> waveform_output_override ==
    ($past(io_wdata[5:4], 2) != 2'h0))
    else $error("override does not follow output mode");
  AST_FORCE_LEVEL: assert property (
    ctrl_wr && io_wdata[7] && !io_wdata[3] && io_wdata[5] |-> ##2
    (waveform_output_pin == $past(io_wdata[4], 2)))
    else $error("forced clear or set missed");
  AST_FORCE_TOGGLE: assert property (
    ctrl_wr && io_wdata[7:3] == 5'h12 && io_wdata[2:0] == 3'h0 |-> ##2
    (waveform_output_pin != $past(waveform_output_pin)))
    else $error("forced toggle missed");
  AST_FORCE_PWM_IGNORED: assert property (
    ctrl_wr && io_wdata[7] && io_wdata[3] && io_wdata[2:0] == 3'h0 |=>
    $stable(waveform_output_pin) [*3])
    else $error("force acted in a PWM mode");
  AST_STOPPED_SILENT: assert property (
    stop_cnt > 4'h6 |-> !$rose(overflow_flag) && !$rose(compare_match_flag))
    else $error("flag rose while stopped");
  AST_FLAG_STICKY: assert property (
    compare_match_flag && !compare_flag_clear |=> compare_match_flag)
    else $error("compare flag dropped by itself");
endmodule : timer8_checker

bind timer8_control_and_counter timer8_checker i_timer8_checker (
  .clk(clk), .rst(rst), .io_addr(io_addr), .io_data_space(io_data_space),
  .io_write(io_write), .io_read(io_read), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .compare_flag_clear(compare_flag_clear),
  .compare_match_flag(compare_match_flag), .overflow_flag(overflow_flag),
  .waveform_output_pin(waveform_output_pin),
  .waveform_output_override(waveform_output_override)
);

// ===== verilog/timer8_control_and_counter.sv
// Purpose: Control and count registers of an 8-bit waveform timer.
// Assumes: Single-cycle I/O strobes on clk; oscillator pin asynchronous.
// Notes: Compare value and flags are reached through side ports.
//
// What this block does
// - Force strobe only acts in non-PWM modes.
// - Force strobe applies match using current output mode.
// - Force sets no flag, never clears counter.
// - Force strobe bit always reads zero.
// - Nonzero output mode overrides the pin function.
// - Non-PWM codes: off, toggle, clear, set.
// - Fast PWM: clear/set on match, inverse at bottom.
// - Fast PWM compare at top: only bottom action.
// - Phase PWM: action by counting direction on match.
// - Phase PWM compare at top: action at top.
// - Clock select: stop, direct, or prescaled divisions.
// - Two mode bits pick mode and top value.
// - Compare update timing and overflow point per mode.
// - Count register readable, writable, resets to zero.
// - Count write blocks match on next tick.
// - Registers at I/O offsets, data space adds 0x20.
// - Count is compared with compare value continuously.
// - Match flag set on real match, cleared externally.
// - Source is I/O clock or oscillator pin.
`timescale 1ns/1ps
module timer8_control_and_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // I/O register port
  input wire logic [7:0] io_addr,
  input wire logic io_data_space,
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Compare value and flags
  input wire logic compare_value_write,
  input wire logic [7:0] compare_value_wdata,
  input wire logic compare_flag_clear,
  input wire logic overflow_flag_clear,
  output logic compare_match_flag,
  output logic overflow_flag,
  // Clock source
  input wire logic async_clock_select,
  input wire logic osc_pin,
  // Waveform pin
  output logic waveform_output_pin,
  output logic waveform_output_override
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [7:0] cmp_active;
    logic [7:0] cmp_buffer;
    logic down;
    logic block;
    logic ovf;
    logic cmpf;
    logic [7:0] rdata;
    logic override;
    logic [2:0] sync;
    logic osc_level;
    logic src_tick;
    logic ev_match;
    logic ev_up;
    logic ev_bottom;
    logic ev_top;
    logic ev_force;
  } st_s;

  st_s st;
  st_s next_st;
  timer8_link_if link ();

  timer8_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .link(link)
  );

  timer8_wavegen u_wavegen (
    .clk(clk),
    .rst(rst),
    .link(link)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [7:0] addr,
    input logic data_space, input logic [7:0] offset);
    reg_hit = data_space ?
      (addr == 8'(offset + timer8_pkg::OFF_DATA_SPACE)) :
      (addr == offset);
  endfunction : reg_hit

  function automatic timer8_pkg::wave_mode_e mode_of(
    input logic [7:0] ctrl);
    mode_of = timer8_pkg::wave_mode_e'({ctrl[timer8_pkg::BIT_WAVE_HI],
      ctrl[timer8_pkg::BIT_WAVE_LO]});
  endfunction : mode_of

  function automatic logic is_pwm(input timer8_pkg::wave_mode_e m);
    is_pwm = (m == timer8_pkg::MODE_FAST_PWM) ||
      (m == timer8_pkg::MODE_PHASE_PWM);
  endfunction : is_pwm

  // ****************************************************************
  // Combinational next state
  // ****************************************************************
  timer8_pkg::wave_mode_e mode;
  logic [1:0] com;
  logic [7:0] top;
  logic hit_ctrl;
  logic hit_count;
  logic match;
  logic ignore;
  logic ovf_set;

  always_comb begin
    mode = mode_of(st.ctrl);
    com = st.ctrl[timer8_pkg::BIT_COM_HI:timer8_pkg::BIT_COM_LO];
    // Only clear-on-match takes its top from the compare value.
    top = (mode == timer8_pkg::MODE_CLEAR_ON_MATCH) ?
      st.cmp_active : timer8_pkg::COUNT_MAX;
    hit_ctrl = reg_hit(io_addr, io_data_space, timer8_pkg::OFF_CTRL);
    hit_count = reg_hit(io_addr, io_data_space, timer8_pkg::OFF_COUNT);
    match = (st.count == st.cmp_active) && !st.block;
    // A compare at top with the high output-mode bit set is replaced by
    // the bottom or top action in the PWM modes.
    ignore = is_pwm(mode) && com[1] &&
      (st.cmp_active == timer8_pkg::COUNT_MAX);

    next_st = st;
    next_st.ev_match = 1'b0;
    next_st.ev_bottom = 1'b0;
    next_st.ev_top = 1'b0;
    next_st.ev_force = 1'b0;
    next_st.ev_up = !st.down;
    ovf_set = 1'b0;

    // Oscillator pin: three stages, a change counts when two agree.
    next_st.sync = {st.sync[1:0], osc_pin};
    next_st.src_tick = 1'b0;
    if (st.sync[2] == st.sync[1]) begin
      next_st.osc_level = st.sync[2];
    end
    if (async_clock_select) begin
      next_st.src_tick = (st.sync[2] == st.sync[1]) && st.sync[2] &&
        !st.osc_level;
    end else begin
      next_st.src_tick = 1'b1;
    end

    // Counting on each timer tick.
    if (link.count_tick) begin
      next_st.block = 1'b0;
      next_st.ev_match = match && !ignore;
      if (match) begin
        next_st.cmpf = 1'b1;
      end
      if (mode == timer8_pkg::MODE_PHASE_PWM) begin
        if (!st.down) begin
          if (st.count == timer8_pkg::COUNT_MAX) begin
            next_st.down = 1'b1;
            next_st.count = 8'(st.count - 8'h01);
            next_st.ev_top = ignore;
            next_st.cmp_active = st.cmp_buffer;
          end else begin
            next_st.count = 8'(st.count + 8'h01);
          end
        end else begin
          if (st.count == timer8_pkg::COUNT_BOTTOM) begin
            next_st.down = 1'b0;
            next_st.count = 8'(st.count + 8'h01);
            next_st.ovf = 1'b1;
            ovf_set = 1'b1;
          end else begin
            next_st.count = 8'(st.count - 8'h01);
          end
        end
      end else begin
        next_st.down = 1'b0;
        if (st.count == timer8_pkg::COUNT_MAX) begin
          next_st.ovf = 1'b1;
          ovf_set = 1'b1;
        end
        if (st.count == top) begin
          next_st.count = timer8_pkg::COUNT_BOTTOM;
          next_st.ev_bottom = (mode == timer8_pkg::MODE_FAST_PWM);
          if (mode == timer8_pkg::MODE_FAST_PWM) begin
            next_st.cmp_active = st.cmp_buffer;
          end
        end else begin
          next_st.count = 8'(st.count + 8'h01);
        end
      end
    end

    // Compare value writes; immediate outside the PWM modes.
    if (compare_value_write) begin
      next_st.cmp_buffer = compare_value_wdata;
      if (!is_pwm(mode)) begin
        next_st.cmp_active = compare_value_wdata;
      end
    end

    // Register writes win over the tick in the same cycle.
    if (io_write && hit_ctrl) begin
      next_st.ctrl = io_wdata & timer8_pkg::CTRL_WRITE_MASK;
      // The strobe is held for no cycle; it only raises one event,
      // and it touches neither the flags nor the count.
      next_st.ev_force = io_wdata[timer8_pkg::BIT_FORCE] &&
        !is_pwm(mode_of(io_wdata));
    end else if (io_write && hit_count) begin
      next_st.count = io_wdata;
      next_st.block = 1'b1;
    end

    // Flag clears lose against a set in the same cycle.
    if (compare_flag_clear && !(link.count_tick && match)) begin
      next_st.cmpf = 1'b0;
    end
    // A new overflow wins even when the flag was already set.
    if (overflow_flag_clear && !ovf_set) begin
      next_st.ovf = 1'b0;
    end

    if (io_read) begin
      if (hit_ctrl) begin
        next_st.rdata = st.ctrl & timer8_pkg::CTRL_WRITE_MASK;
      end else if (hit_count) begin
        next_st.rdata = st.count;
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    next_st.override = (next_st.ctrl[timer8_pkg::BIT_COM_HI] ||
      next_st.ctrl[timer8_pkg::BIT_COM_LO]);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= timer8_pkg::RST_CTRL;
      st.count <= timer8_pkg::RST_COUNT;
      st.cmp_active <= timer8_pkg::RST_COMPARE;
      st.cmp_buffer <= timer8_pkg::RST_COMPARE;
      st.sync <= timer8_pkg::SYNC_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Link and outputs
  // ****************************************************************
  assign link.src_tick = st.src_tick;
  assign link.clock_select =
    st.ctrl[timer8_pkg::BIT_CS_HI:timer8_pkg::BIT_CS_LO];
  assign link.mode = mode_of(st.ctrl);
  assign link.com = timer8_pkg::com_mode_e'(
    st.ctrl[timer8_pkg::BIT_COM_HI:timer8_pkg::BIT_COM_LO]);
  assign link.ev_match = st.ev_match;
  assign link.ev_up = st.ev_up;
  assign link.ev_bottom = st.ev_bottom;
  assign link.ev_top = st.ev_top;
  assign link.ev_force = st.ev_force;

  assign io_rdata = st.rdata;
  assign compare_match_flag = st.cmpf;
  assign overflow_flag = st.ovf;
  assign waveform_output_pin = link.wave_out;
  assign waveform_output_override = st.override;

endmodule : timer8_control_and_counter

// ===== verilog/timer8_prescaler.sv
// Purpose: Divides the selected source tick by the clock select code.
// Assumes: src_tick is a one-cycle enable at the source rate.
// Notes: Prescaler is free running; it is never reset by software here.
`timescale 1ns/1ps
module timer8_prescaler #(
  parameter int WIDTH = timer8_pkg::PRESCALE_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the counter
  timer8_link_if.pre link
);

  typedef struct packed {
    logic [WIDTH-1:0] div;
    logic tick;
  } st_s;

  st_s st;
  st_s next_st;

  // Low bits that must be all ones for each prescaled rate.
  function automatic logic [WIDTH-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h2: div_mask = WIDTH'(10'h007);
      3'h3: div_mask = WIDTH'(10'h01F);
      3'h4: div_mask = WIDTH'(10'h03F);
      3'h5: div_mask = WIDTH'(10'h07F);
      3'h6: div_mask = WIDTH'(10'h0FF);
      default: div_mask = WIDTH'(10'h3FF);
    endcase
  endfunction : div_mask

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (link.src_tick) begin
      next_st.div = st.div + WIDTH'(1);
      if (link.clock_select == 3'h1) begin
        next_st.tick = 1'b1;
      end else if (link.clock_select != 3'h0) begin
        next_st.tick = ((st.div & div_mask(link.clock_select)) ==
          div_mask(link.clock_select));
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.count_tick = st.tick;

endmodule : timer8_prescaler

// ===== verilog/timer8_wavegen.sv
// Purpose: Drives the waveform output level from qualified events.
// Assumes: Events arrive already filtered for blocked or ignored matches.
// Notes: Reserved codes in PWM modes leave the level unchanged.
`timescale 1ns/1ps
module timer8_wavegen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the counter
  timer8_link_if.wave link
);

  typedef struct packed {
    logic level;
  } st_s;

  st_s st;
  st_s next_st;

  always_comb begin
    next_st = st;
    case (link.mode)
      timer8_pkg::MODE_FAST_PWM: begin
        if (link.ev_match && link.com[1]) begin
          next_st.level = link.com[0];
        end
        if (link.ev_bottom && link.com[1]) begin
          next_st.level = ~link.com[0];
        end
      end
      timer8_pkg::MODE_PHASE_PWM: begin
        if ((link.ev_match || link.ev_top) && link.com[1]) begin
          // Top acts like an up-count match to stay symmetric.
          next_st.level = (link.ev_up || link.ev_top) ?
            link.com[0] : ~link.com[0];
        end
      end
      default: begin
        if (link.ev_match || link.ev_force) begin
          case (link.com)
            timer8_pkg::COM_TOGGLE: next_st.level = ~st.level;
            timer8_pkg::COM_CLEAR: next_st.level = 1'b0;
            timer8_pkg::COM_SET: next_st.level = 1'b1;
            default: next_st.level = st.level;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.wave_out = st.level;

endmodule : timer8_wavegen
